// >>> sim/cpu_data_memory_map_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_data_memory_map_tb_top
  import dmem_pkg::*;
;
  logic clk;
  logic rst;
  logic [7:0] alu_flags;
  logic alu_flags_we;
  req_s req;
  rsp_s rsp;
  logic [7:0] primary_operand;
  logic [7:0] second_operand;
  logic [1:0] active_bank;
  logic [7:0] rd;
  int num_errors = 0;
  int n_compared = 0;

  cpu_data_memory_map cpu_data_memory_map_i (
    .clk(clk), .rst(rst), .req(req), .alu_flags(alu_flags),
    .alu_flags_we(alu_flags_we), .rsp(rsp), .primary_operand(primary_operand),
    .second_operand(second_operand), .active_bank(active_bank)
  );
  cpu_seq_model cpu_seq_model_i (.clk(clk), .rsp(rsp), .req(req));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input op_e op, input logic wr, input logic [7:0] a, input logic [7:0] d);
    cpu_seq_model_i.issue(op, wr, a, d, 16'h0000, rd);
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    acc(OP_DIRECT, 1'b1, a, d);
  endtask
  task automatic rchk(input op_e op, input logic [7:0] a, input logic [7:0] exp);
    acc(op, 1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  task automatic results();
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic t_reset();
    chk(rsp.sp, SP_RESET);
    for (int i = 0; i < 3; i++) begin
      rchk(OP_DIRECT, FLAG_ADDR + 8'(16 * i), ZERO_RESET);
    end
    rchk(OP_DIRECT, 8'h84, UNIMPL_READ);
    rchk(OP_BIT, 8'h81, 8'h01);
    // A bit write to an absent register must not stick
    acc(OP_BIT, 1'b1, 8'h88, 8'h00);
    rchk(OP_BIT, 8'h88, 8'h01);
    wr8(DPL_ADDR, 8'hcd);
    wr8(DPH_ADDR, 8'hab);
    chk(rsp.data_pointer16[15:8], 8'hab);
    chk(rsp.data_pointer16[7:0], 8'hcd);
  endtask

  task automatic t_stack();
    wr8(SP_ADDR, 8'hfe);
    chk(rd, SP_RESET);
    acc(OP_PUSH, 1'b1, 8'h00, 8'ha1);
    chk(rsp.sp, 8'hff);
    acc(OP_PUSH, 1'b1, 8'h00, 8'hb2);
    chk(rsp.sp, 8'h00);
    rchk(OP_POP, 8'h00, 8'hb2);
    chk(rsp.sp, 8'hff);
    rchk(OP_POP, 8'h00, 8'ha1);
    acc(OP_BANKREG, 1'b1, 8'h00, 8'hff);
    rchk(OP_INDIRECT, 8'h00, 8'ha1);
    wr8(SP_ADDR, 8'h07);
    cpu_seq_model_i.issue(OP_CALL, 1'b0, 8'h00, 8'h00, 16'h1234, rd);
    // High byte goes in one edge after the answer
    @(posedge clk);
    #1;
    chk(rsp.sp, 8'h09);
    rchk(OP_POP, 8'h00, 8'h12);
    rchk(OP_POP, 8'h00, 8'h34);
  endtask

  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      wr8(FLAG_ADDR, 8'(b << 3));
      chk({6'h00, active_bank}, 8'(b));
      acc(OP_BANKREG, 1'b1, 8'h01, 8'(8'h40 + b));
    end
    // Second pass proves the banks hold separate copies
    for (int b = 0; b < 4; b++) begin
      wr8(FLAG_ADDR, 8'(b << 3));
      rchk(OP_BANKREG, 8'h01, 8'(8'h40 + b));
      acc(OP_INDIRECT, 1'b1, 8'h01, 8'(8'h90 + b));
    end
    rchk(OP_DIRECT, 8'h42, 8'h92);
    wr8(PRI_ADDR, 8'h11);
    acc(OP_BANKREG, 1'b1, 8'h01, PRI_ADDR);
    acc(OP_INDIRECT, 1'b1, 8'h01, 8'h5a);
    chk(primary_operand, 8'h11);
    rchk(OP_INDIRECT, 8'h01, 8'h5a);
  endtask

  task automatic t_bits();
    wr8(8'h2f, 8'h00);
    acc(OP_BIT, 1'b1, 8'h7f, 8'h01);
    rchk(OP_DIRECT, 8'h2f, 8'h80);
    wr8(8'h24, 8'h00);
    wr8(8'h20, 8'h00);
    acc(OP_BIT, 1'b1, 8'h20, 8'h01);
    rchk(OP_DIRECT, 8'h20, 8'h00);
    rchk(OP_DIRECT, 8'h24, 8'h01);
    wr8(PRI_ADDR, 8'h00);
    acc(OP_BIT, 1'b1, 8'he3, 8'h01);
    chk(primary_operand, 8'h08);
    wr8(SEC_ADDR, 8'h0f);
    acc(OP_BIT, 1'b1, 8'hf7, 8'h01);
    chk(second_operand, 8'h8f);
    wr8(FLAG_ADDR, 8'h00);
    acc(OP_BIT, 1'b1, 8'hd4, 8'h01);
    chk({6'h00, active_bank}, 8'h02);
    @(posedge clk);
    #1;
    alu_flags = 8'hff;
    alu_flags_we = 1'b1;
    @(posedge clk);
    #1;
    alu_flags_we = 1'b0;
    rchk(OP_DIRECT, FLAG_ADDR, 8'hd5);
  endtask

  initial begin
    rst = 1'b1;
    alu_flags = 8'h00;
    alu_flags_we = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_stack();
    t_banks();
    t_bits();
    results();
  end

  // Whole run is about 150 cycles; the 2000-cycle limit leaves wide margin
  initial begin
    #20000;
    num_errors++;
    $display("Error %0t: timeout", $time);
    results();
  end
endmodule
`default_nettype wire

// >>> sim/cpu_seq_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_seq_model
  import dmem_pkg::*;
(
  input wire logic clk,
  input wire rsp_s rsp,
  output var req_s req
);
  initial req = '0;
  // One request per call and an idle cycle after it, so a call's dead cycle is kept
  task automatic issue(input op_e op, input logic wr, input logic [7:0] a,
      input logic [7:0] d, input logic [15:0] ra, output logic [7:0] rd);
    @(posedge clk);
    #1;
    req = '{op, wr, a, d, d[0], ra};
    @(posedge clk);
    #1;
    // Released fields show inverted values so a stale sample cannot pass
    req = '{OP_IDLE, ~wr, ~a, ~d, ~d[0], ~ra};
    for (int i = 0; i < 3 && rsp.valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    rd = (op == OP_BIT) ? {7'h00, rsp.rbit} : rsp.rdata;
    if (rsp.valid !== 1'b1 && op != OP_CALL) begin
      rd = 8'hxx;
    end
  endtask
endmodule
`default_nettype wire

// >>> verilog/cpu_data_memory_map.sv
// Overview of operation
// - Four banks of eight registers, one active
// - Flag word bank bits pick the bank
// - Bank registers zero and one point indirectly
// - Bytes 20h to 2Fh are bit addressable
// - Special registers ending 0 or 8 bit-accessible
// - Special space 80h-FFh only by direct or bit access
// - Scratch-pad reached directly and indirectly
// - Stack pointer resets to 07h, writable
// - Push increments pointer then writes
// - Pop reads then decrements pointer
// - Calls push return address
// - Eight-bit pointer, stack anywhere in scratch-pad
// - Unimplemented special registers and bits read one
// - Second operand register is general purpose byte
// - Flag word holds arithmetic status bits
// - One sixteen-bit data pointer, two bytes
// - Bit or byte chosen by operation type
`timescale 1ns/100ps
`default_nettype none
module cpu_data_memory_map
  import dmem_pkg::*;
#(
  parameter int RAM_DEPTH = 256
) (
  input wire logic clk,
  input wire logic rst,
  input wire req_s req,
  input wire logic [7:0] alu_flags,
  input wire logic alu_flags_we,
  output rsp_s rsp,
  output logic [7:0] primary_operand,
  output logic [7:0] second_operand,
  output logic [1:0] active_bank
);
  if (RAM_DEPTH != 256) begin : g_chk
    $error("RAM_DEPTH must be 256");
  end

  logic [7:0] ram_q [RAM_DEPTH];
  logic [7:0] sp_q, sp_d, dpl_q, dpl_d, dph_q, dph_d;
  logic [7:0] flag_q, flag_d, pri_q, pri_d, sec_q, sec_d;
  logic [7:0] rdata_q, rdata_d;
  logic rbit_q, rbit_d, valid_q, valid_d;
  logic [15:0] ret_q, ret_d;
  logic call_hi_q, call_hi_d;
  logic ram_we;
  logic [7:0] ram_wa, ram_wd;
  logic [7:0] bank_reg_a, ptr_addr, bit_byte, sfr_rd, cur_byte, new_byte;
  logic [2:0] bit_idx;
  logic is_sfr, sfr_bitable;

  assign active_bank = {flag_q[BS_HI_POS], flag_q[BS_LO_POS]};
  assign bank_reg_a = {3'h0, active_bank, req.addr[2:0]};
  // pointer from register zero or one
  assign ptr_addr = ram_q[{3'h0, active_bank, 2'h0, req.addr[0]}];

  // bit area maps to 20h..2Fh; special bits in 0/8 bytes
  assign is_sfr = req.addr[7];
  assign bit_byte = is_sfr ? {req.addr[7:3], 3'h0} : (BITAREA_BASE + {4'h0, req.addr[6:3]});
  assign bit_idx = req.addr[2:0];

  function automatic logic [7:0] sfr_read(input logic [7:0] a, input logic [7:0] sp,
      input logic [7:0] dl, input logic [7:0] dh, input logic [7:0] fl,
      input logic [7:0] pr, input logic [7:0] se);
    case (a)
      SP_ADDR: sfr_read = sp;
      DPL_ADDR: sfr_read = dl;
      DPH_ADDR: sfr_read = dh;
      FLAG_ADDR: sfr_read = fl;
      PRI_ADDR: sfr_read = pr;
      SEC_ADDR: sfr_read = se;
      default: sfr_read = UNIMPL_READ;
    endcase
  endfunction

  always_comb begin
    sfr_rd = sfr_read(is_sfr ? bit_byte : req.addr, sp_q, dpl_q, dph_q, flag_q, pri_q, sec_q);
    cur_byte = is_sfr ? sfr_rd : ram_q[bit_byte];
    new_byte = cur_byte;
    new_byte[bit_idx] = req.bit_val;
    sfr_bitable = (bit_byte == FLAG_ADDR) || (bit_byte == PRI_ADDR) || (bit_byte == SEC_ADDR);
  end

  always_comb begin
    sp_d = sp_q;
    dpl_d = dpl_q;
    dph_d = dph_q;
    flag_d = flag_q;
    pri_d = pri_q;
    sec_d = sec_q;
    rdata_d = rdata_q;
    rbit_d = rbit_q;
    valid_d = 1'b0;
    ret_d = ret_q;
    call_hi_d = 1'b0;
    ram_we = 1'b0;
    ram_wa = 8'h00;
    ram_wd = 8'h00;
    if (alu_flags_we) begin
      flag_d[CY_POS] = alu_flags[CY_POS];
      flag_d[AC_POS] = alu_flags[AC_POS];
      flag_d[OV_POS] = alu_flags[OV_POS];
      flag_d[P_POS] = alu_flags[P_POS];
    end
    if (call_hi_q) begin
      sp_d = sp_q + 8'h01;
      ram_we = 1'b1;
      ram_wa = sp_d;
      ram_wd = ret_q[15:8];
    end else begin
      case (req.op)
        OP_DIRECT: begin
          valid_d = 1'b1;
          if (is_sfr) begin
            rdata_d = sfr_read(req.addr, sp_q, dpl_q, dph_q, flag_q, pri_q, sec_q);
            if (req.wr) begin
              case (req.addr)
                SP_ADDR: sp_d = req.wdata;
                DPL_ADDR: dpl_d = req.wdata;
                DPH_ADDR: dph_d = req.wdata;
                FLAG_ADDR: flag_d = req.wdata;
                PRI_ADDR: pri_d = req.wdata;
                SEC_ADDR: sec_d = req.wdata;
                default: ;
              endcase
            end
          end else begin
            rdata_d = ram_q[req.addr];
            ram_we = req.wr;
            ram_wa = req.addr;
            ram_wd = req.wdata;
          end
        end
        OP_INDIRECT: begin
          // indirect reaches all 256 bytes, never special space
          valid_d = 1'b1;
          rdata_d = ram_q[ptr_addr];
          ram_we = req.wr;
          ram_wa = ptr_addr;
          ram_wd = req.wdata;
        end
        OP_BANKREG: begin
          valid_d = 1'b1;
          rdata_d = ram_q[bank_reg_a];
          ram_we = req.wr;
          ram_wa = bank_reg_a;
          ram_wd = req.wdata;
        end
        OP_BIT: begin
          valid_d = 1'b1;
          rbit_d = cur_byte[bit_idx];
          if (req.wr) begin
            if (!is_sfr) begin
              ram_we = 1'b1;
              ram_wa = bit_byte;
              ram_wd = new_byte;
            end else if (sfr_bitable) begin
              case (bit_byte)
                FLAG_ADDR: flag_d = new_byte;
                PRI_ADDR: pri_d = new_byte;
                default: sec_d = new_byte;
              endcase
            end
          end
        end
        OP_PUSH: begin
          valid_d = 1'b1;
          sp_d = sp_q + 8'h01;
          ram_we = 1'b1;
          ram_wa = sp_d;
          ram_wd = req.wdata;
        end
        OP_POP: begin
          valid_d = 1'b1;
          rdata_d = ram_q[sp_q];
          sp_d = sp_q - 8'h01;
        end
        OP_CALL: begin
          // low byte first, high byte next cycle
          valid_d = 1'b1;
          sp_d = sp_q + 8'h01;
          ram_we = 1'b1;
          ram_wa = sp_d;
          ram_wd = req.ret_addr[7:0];
          ret_d = req.ret_addr;
          call_hi_d = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_q <= SP_RESET;
      dpl_q <= ZERO_RESET;
      dph_q <= ZERO_RESET;
      flag_q <= ZERO_RESET;
      pri_q <= ZERO_RESET;
      sec_q <= ZERO_RESET;
      rdata_q <= ZERO_RESET;
      rbit_q <= 1'b0;
      valid_q <= 1'b0;
      ret_q <= 16'h0000;
      call_hi_q <= 1'b0;
    end else begin
      sp_q <= sp_d;
      dpl_q <= dpl_d;
      dph_q <= dph_d;
      flag_q <= flag_d;
      pri_q <= pri_d;
      sec_q <= sec_d;
      rdata_q <= rdata_d;
      rbit_q <= rbit_d;
      valid_q <= valid_d;
      ret_q <= ret_d;
      call_hi_q <= call_hi_d;
    end
  end

  // Scratch-pad has no reset, as real RAM would not
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram_q[ram_wa] <= ram_wd;
    end
  end

  assign rsp = '{rdata: rdata_q, rbit: rbit_q, valid: valid_q, sp: sp_q, data_pointer16: {dph_q, dpl_q}};
  assign primary_operand = pri_q;
  assign second_operand = sec_q;

  property p_sp_reset;
    @(posedge clk) $fell(rst) |-> sp_q == SP_RESET;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("sp not 07h after reset");

  sequence s_push;
    req.op == OP_PUSH && !call_hi_q;
  endsequence
  property p_push;
    @(posedge clk) disable iff (rst) s_push |=> sp_q == 8'($past(sp_q) + 8'h01)
      ##0 ram_q[sp_q] == $past(req.wdata);
  endproperty
  a_push: assert property (p_push) else $error("push order wrong");

  logic [7:0] top_byte;
  assign top_byte = ram_q[sp_q];

  property p_pop;
    @(posedge clk) disable iff (rst) (req.op == OP_POP && !call_hi_q)
      |=> valid_q && sp_q == 8'($past(sp_q) - 8'h01) && rdata_q == $past(top_byte);
  endproperty
  a_pop: assert property (p_pop) else $error("pop order wrong");

  sequence s_call_lo;
    req.op == OP_CALL && !call_hi_q;
  endsequence
  // Low byte lands first, high byte one cycle later
  property p_call;
    @(posedge clk) disable iff (rst) s_call_lo
      |=> call_hi_q && ram_q[sp_q] == $past(req.ret_addr[7:0])
      ##1 sp_q == 8'($past(sp_q, 2) + 8'h02) && ram_q[sp_q] == $past(req.ret_addr[15:8], 2);
  endproperty
  a_call: assert property (p_call) else $error("call push wrong");

  property p_unimpl;
    @(posedge clk) disable iff (rst) (req.op == OP_DIRECT && !call_hi_q && req.addr == 8'h84)
      |=> rdata_q == UNIMPL_READ;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented not ones");

  // Bank register write lands in the bank named by the flag word
  property p_bank;
    @(posedge clk) disable iff (rst) (req.op == OP_BANKREG && req.wr && !call_hi_q)
      |=> ram_q[{3'h0, $past(flag_q[BS_HI_POS]), $past(flag_q[BS_LO_POS]), $past(req.addr[2:0])}]
      == $past(req.wdata);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select mismatch");

  property p_ind_no_sfr;
    @(posedge clk) disable iff (rst) (req.op == OP_INDIRECT && !call_hi_q && req.wr)
      |=> $stable(pri_q) && $stable(sec_q) && $stable(dpl_q);
  endproperty
  a_ind_no_sfr: assert property (p_ind_no_sfr) else $error("indirect hit special");

  property p_bit_keep;
    @(posedge clk) disable iff (rst)
      (req.op == OP_BIT && !call_hi_q && req.wr && req.addr[7:3] == 5'h1c && !alu_flags_we)
      |=> pri_q[$past(bit_idx)] == $past(req.bit_val)
      && ((pri_q ^ $past(pri_q)) & ~(8'h01 << $past(bit_idx))) == 8'h00;
  endproperty
  a_bit_keep: assert property (p_bit_keep) else $error("bit write lost");
endmodule
`default_nettype wire

// >>> verilog/dmem_pkg.sv
package dmem_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] SP_ADDR = 8'h81;
  localparam logic [7:0] DPL_ADDR = 8'h82;
  localparam logic [7:0] DPH_ADDR = 8'h83;
  localparam logic [7:0] FLAG_ADDR = 8'hd0;
  localparam logic [7:0] PRI_ADDR = 8'he0;
  localparam logic [7:0] SEC_ADDR = 8'hf0;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  localparam logic [7:0] UNIMPL_READ = 8'hff;
  localparam logic [7:0] BITAREA_BASE = 8'h20;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam int BS_HI_POS = 4;
  localparam int BS_LO_POS = 3;
  localparam int CY_POS = 7;
  localparam int AC_POS = 6;
  localparam int OV_POS = 2;
  localparam int P_POS = 0;
  localparam int REGS_PER_BANK = 8;
  localparam int NUM_BANKS = 4;
  typedef enum logic [2:0] {
    OP_IDLE = 3'h0,
    OP_DIRECT = 3'h1,
    OP_INDIRECT = 3'h3,
    OP_BANKREG = 3'h2,
    OP_BIT = 3'h6,
    OP_PUSH = 3'h7,
    OP_POP = 3'h5,
    OP_CALL = 3'h4
  } op_e;
  typedef struct packed {
    op_e op;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic bit_val;
    logic [15:0] ret_addr;
  } req_s;
  typedef struct packed {
    logic [7:0] rdata;
    logic rbit;
    logic valid;
    logic [7:0] sp;
    logic [15:0] data_pointer16;
  } rsp_s;
endpackage
